//--- dv/data_break_port_test.sv
// self-checking bench: processor end and device end joined by the link
// assumes a flat memory model here answers reads combinationally
`timescale 1ns/1ps
module data_break_port_test;
    logic                       ref_clk;
    logic                       rst_b;
    logic                       instr_done;
    logic                       mem_re;
    logic                       mem_we;
    logic [dbp_pkg::ADDR_W-1:0] mem_addr;
    logic [dbp_pkg::DATA_W-1:0] mem_wdata;
    logic [dbp_pkg::DATA_W-1:0] mem_rdata;
    logic                       break_pending;
    logic                       break_state;
    logic                       cmd_valid;
    logic                       cmd_ready;
    logic                       cmd_dir_in;
    logic [dbp_pkg::ADDR_W-1:0] cmd_addr;
    logic [dbp_pkg::DATA_W-1:0] cmd_data;
    logic                       rd_valid;
    logic                       rd_ready;
    logic [dbp_pkg::DATA_W-1:0] rd_data;
    logic [dbp_pkg::DATA_W-1:0] mem [0:(1<<dbp_pkg::ADDR_W)-1];
    logic [dbp_pkg::ADDR_W-1:0] addr_tab [0:2];
    logic [dbp_pkg::DATA_W-1:0] data_tab [0:2];
    int                         err_count;
    int                         samples_checked;
    int                         wr_count;

    dbp_link_if dbp_link_if_inst ();
    dbp_proc dbp_proc_inst (.REF_CLK(ref_clk), .RST_B(rst_b),
        .LINK(dbp_link_if_inst), .INSTR_DONE(instr_done),
        .MEM_RDATA(mem_rdata), .MEM_RE(mem_re), .MEM_WE(mem_we),
        .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
        .BREAK_PENDING(break_pending), .BREAK_STATE(break_state));
    dbp_dev dbp_dev_inst (.REF_CLK(ref_clk), .RST_B(rst_b),
        .LINK(dbp_link_if_inst), .CMD_VALID(cmd_valid),
        .CMD_READY(cmd_ready), .CMD_DIR_IN(cmd_dir_in),
        .CMD_ADDR(cmd_addr), .CMD_DATA(cmd_data), .RD_VALID(rd_valid),
        .RD_READY(rd_ready), .RD_DATA(rd_data));
    dbp_link_chk dbp_link_chk_inst (.REF_CLK(ref_clk), .RST_B(rst_b),
        .break_request(dbp_link_if_inst.break_request),
        .device_address_lines(dbp_link_if_inst.device_address_lines),
        .data_in_dir(dbp_link_if_inst.data_in_dir),
        .inbound_data_lines(dbp_link_if_inst.inbound_data_lines),
        .address_accept_pulse(dbp_link_if_inst.address_accept_pulse),
        .inbound_strobe(dbp_link_if_inst.inbound_strobe),
        .outbound_strobe(dbp_link_if_inst.outbound_strobe),
        .buffered_memory_out(dbp_link_if_inst.buffered_memory_out));

    // memory model: read follows the address register, write on strobe
    assign mem_rdata = mem[mem_addr];
    always @(posedge ref_clk) begin
        if (mem_we === 1'b1) begin
            mem[mem_addr] <= mem_wdata;
            wr_count <= wr_count + 1;
        end
    end

    // 10 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end

    task automatic wrap_up();
        if (err_count == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic check_word(input logic [dbp_pkg::DATA_W-1:0] got,
                              input logic [dbp_pkg::DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // offer one command, hold it until taken, then let an edge pass
    task automatic send_cmd(input logic dir,
                            input logic [dbp_pkg::ADDR_W-1:0] a,
                            input logic [dbp_pkg::DATA_W-1:0] d);
        int n;
        cmd_valid <= 1'b1;
        cmd_dir_in <= dir;
        cmd_addr <= a;
        cmd_data <= d;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (cmd_ready !== 1'b1 && n < 200);
        if (n >= 200) err_count++;
        cmd_valid <= 1'b0;
        @(posedge ref_clk);
    endtask

    // take one outbound word and compare it
    task automatic read_word(input logic [dbp_pkg::DATA_W-1:0] exp);
        int n;
        rd_ready <= 1'b1;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (rd_valid !== 1'b1 && n < 200);
        if (n >= 200) err_count++;
        check_word(rd_data, exp);
        rd_ready <= 1'b0;
        @(posedge ref_clk);
    endtask

    // hang guard, well past the expected hundred or so cycles
    initial begin
        repeat (3000) @(posedge ref_clk);
        err_count++;
        wrap_up();
    end

    initial begin
        rst_b = 1'b0;
        instr_done = 1'b0;
        cmd_valid = 1'b0;
        cmd_dir_in = 1'b0;
        cmd_addr = 15'h0000;
        cmd_data = 18'h00000;
        rd_ready = 1'b0;
        err_count = 0;
        samples_checked = 0;
        wr_count = 0;
        addr_tab = '{15'h0000, 15'h2d4b, 15'h7fff};
        data_tab = '{18'h3ffff, 18'h00000, 18'h2a5a5};
        repeat (3) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        // instruction not finishing: request pends, no break yet
        for (int i = 0; i < 2; i++) send_cmd(1'b1, addr_tab[i], data_tab[i]);
        repeat (8) @(posedge ref_clk);
        check_flag(break_pending, 1'b1);
        check_flag(break_state, 1'b0);
        instr_done <= 1'b1;
        send_cmd(1'b1, addr_tab[2], data_tab[2]);
        for (int n = 0; n < 200 && wr_count < 3; n++) @(posedge ref_clk);
        check_flag(wr_count == 3, 1'b1);
        for (int i = 0; i < 3; i++) check_word(mem[addr_tab[i]], data_tab[i]);
        // outbound with the reader stalled until the read buffer fills
        for (int i = 0; i < 3; i++) send_cmd(1'b0, addr_tab[i], 18'h3ffff);
        repeat (30) @(posedge ref_clk);
        check_flag(rd_valid, 1'b1);
        for (int i = 0; i < 3; i++) read_word(data_tab[i]);
        // write then read back the same place, back to back
        send_cmd(1'b1, addr_tab[1], 18'h15a5a);
        send_cmd(1'b0, addr_tab[1], 18'h00000);
        read_word(18'h15a5a);
        wrap_up();
    end
endmodule

//--- dv/dbp_link_assertions.sv
// checker on the link between the processor break port and the device end
// assumes one clock domain; sits beside the link interface in the bench
`timescale 1ns/1ps
module dbp_link_chk (
    input wire logic                       REF_CLK,
    input wire logic                       RST_B,
    input wire logic                       break_request,
    input wire logic [dbp_pkg::ADDR_W-1:0] device_address_lines,
    input wire logic                       data_in_dir,
    input wire logic [dbp_pkg::DATA_W-1:0] inbound_data_lines,
    input wire logic                       address_accept_pulse,
    input wire logic                       inbound_strobe,
    input wire logic                       outbound_strobe,
    input wire logic [dbp_pkg::DATA_W-1:0] buffered_memory_out
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_B);

    // a rising request is served by an accept within 40 clocks
    chk_request_served: assert property (
        $rose(break_request) |-> ##[1:40] address_accept_pulse)
        else $error("request not served by an accept");
    // accept is a single pulse, once per five-phase cycle
    chk_accept_spacing: assert property (
        address_accept_pulse |=> !address_accept_pulse [*4])
        else $error("accept pulse repeated inside a cycle");
    chk_accept_cause: assert property (
        address_accept_pulse |-> $past(break_request))
        else $error("accept without a prior request");
    // strobes only two clocks after an accept, matching the direction
    chk_inbound_strobe: assert property (
        inbound_strobe |-> $past(address_accept_pulse, 2)
                           && $past(data_in_dir, 2))
        else $error("inbound strobe outside an inbound break");
    chk_outbound_strobe: assert property (
        outbound_strobe |-> $past(address_accept_pulse, 2)
                            && !$past(data_in_dir, 2))
        else $error("outbound strobe outside an outbound break");
    chk_strobe_follows: assert property (
        address_accept_pulse |-> ##2 (inbound_strobe || outbound_strobe))
        else $error("no strobe two clocks after accept");
    // captured word shows on the buffered lines
    chk_inbound_capture: assert property (
        inbound_strobe |=>
            buffered_memory_out == $past(inbound_data_lines))
        else $error("buffer does not hold the inbound word");
    // buffer only moves at the load points of a break
    chk_buffer_holds: assert property (
        $changed(buffered_memory_out) |->
            $past(address_accept_pulse) || $past(address_accept_pulse, 2))
        else $error("buffer changed outside a break");
    // device lines steady while its request stands
    chk_lines_steady: assert property (
        break_request && $past(break_request) |->
            $stable(inbound_data_lines) && $stable(device_address_lines)
            && $stable(data_in_dir))
        else $error("device lines moved during a request");
    chk_request_drop: assert property (
        address_accept_pulse |=> !break_request [*2])
        else $error("request not withdrawn after accept");

    cov_inbound: cover property (inbound_strobe);
    cov_outbound: cover property (outbound_strobe);
    cov_back_to_back: cover property (
        address_accept_pulse ##5 address_accept_pulse);
endmodule

//--- hw/dbp_dev.sv
// device end of the data break port with two-entry buffers on each side
// assumes the processor end pulses accept and strobes for one clock each
`timescale 1ns/1ps
module dbp_fifo #(
    parameter int W = 8,
    parameter int D = 2
) (
    input  wire logic         REF_CLK,
    input  wire logic         RST_B,
    input  wire logic         IN_VALID,
    output logic              IN_READY,
    input  wire logic [W-1:0] IN_DATA,
    output logic              OUT_VALID,
    input  wire logic         OUT_READY,
    output logic [W-1:0]      OUT_DATA
);
    localparam int PW = (D > 1) ? $clog2(D) : 1;
    localparam int CW = $clog2(D + 1);

    logic [W-1:0]  mem_r [D];
    logic [PW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
    logic [CW-1:0] cnt_r, cnt_nxt;
    logic          push, pop;

    function automatic logic [PW-1:0] inc(input logic [PW-1:0] p);
        inc = (p == PW'(D - 1)) ? '0 : p + PW'(1);
    endfunction

    // honest full and empty from the fill count
    always_comb begin
        IN_READY  = (cnt_r != CW'(D));
        OUT_VALID = (cnt_r != '0);
        OUT_DATA  = mem_r[rp_r];
        push      = IN_VALID && IN_READY;
        pop       = OUT_VALID && OUT_READY;
        wp_nxt    = push ? inc(wp_r) : wp_r;
        rp_nxt    = pop ? inc(rp_r) : rp_r;
        cnt_nxt   = cnt_r + CW'(push) - CW'(pop);
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            wp_r  <= '0;
            rp_r  <= '0;
            cnt_r <= '0;
        end else begin
            wp_r  <= wp_nxt;
            rp_r  <= rp_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // storage carries no reset; only valid entries are read
    always_ff @(posedge REF_CLK) begin
        if (push) begin
            mem_r[wp_r] <= IN_DATA;
        end
    end
endmodule

module dbp_dev #(
    parameter int DEPTH = dbp_pkg::BUF_DEPTH
) (
    input  wire logic                       REF_CLK,
    input  wire logic                       RST_B,
    dbp_link_if.dev                         LINK,
    input  wire logic                       CMD_VALID,
    output logic                            CMD_READY,
    input  wire logic                       CMD_DIR_IN,
    input  wire logic [dbp_pkg::ADDR_W-1:0] CMD_ADDR,
    input  wire logic [dbp_pkg::DATA_W-1:0] CMD_DATA,
    output logic                            RD_VALID,
    input  wire logic                       RD_READY,
    output logic [dbp_pkg::DATA_W-1:0]      RD_DATA
);
    dbp_pkg::dbp_dstate_t          st_r, st_nxt;
    logic                          req_r, req_nxt;
    logic                          dir_r, dir_nxt;
    logic [dbp_pkg::ADDR_W-1:0]    adr_r, adr_nxt;
    logic [dbp_pkg::DATA_W-1:0]    dat_r, dat_nxt;
    logic                          hd_valid, hd_pop;
    logic [dbp_pkg::CMD_W-1:0]     hd_data;
    logic                          rb_ready, rb_push;

    dbp_fifo #(.W(dbp_pkg::CMD_W), .D(DEPTH)) u_cmd (
        .REF_CLK   (REF_CLK),
        .RST_B     (RST_B),
        .IN_VALID  (CMD_VALID),
        .IN_READY  (CMD_READY),
        .IN_DATA   ({CMD_DIR_IN, CMD_ADDR, CMD_DATA}),
        .OUT_VALID (hd_valid),
        .OUT_READY (hd_pop),
        .OUT_DATA  (hd_data)
    );

    // a stalled reader fills this and holds off further outbound breaks
    dbp_fifo #(.W(dbp_pkg::DATA_W), .D(DEPTH)) u_rd (
        .REF_CLK   (REF_CLK),
        .RST_B     (RST_B),
        .IN_VALID  (rb_push),
        .IN_READY  (rb_ready),
        .IN_DATA   (LINK.buffered_memory_out),
        .OUT_VALID (RD_VALID),
        .OUT_READY (RD_READY),
        .OUT_DATA  (RD_DATA)
    );

    // request sequencer: one break per command
    always_comb begin
        st_nxt  = st_r;
        req_nxt = req_r;
        dir_nxt = dir_r;
        adr_nxt = adr_r;
        dat_nxt = dat_r;
        hd_pop  = 1'b0;
        rb_push = 1'b0;
        case (st_r)
            dbp_pkg::DS_IDLE: begin
                // outbound only with room, so the word is never lost
                if (hd_valid && (hd_data[dbp_pkg::CMD_DIR_B] || rb_ready)) begin
                    dir_nxt = hd_data[dbp_pkg::CMD_DIR_B];
                    adr_nxt = hd_data[dbp_pkg::CMD_ADDR_L +: dbp_pkg::ADDR_W];
                    dat_nxt = hd_data[dbp_pkg::DATA_W-1:0];
                    req_nxt = 1'b1;
                    st_nxt  = dbp_pkg::DS_REQ;
                end
            end
            dbp_pkg::DS_REQ: begin
                if (LINK.address_accept_pulse) begin
                    req_nxt = 1'b0;
                    st_nxt  = dbp_pkg::DS_XFER;
                end
            end
            dbp_pkg::DS_XFER: begin
                if (dir_r && LINK.inbound_strobe) begin
                    hd_pop = 1'b1;
                    st_nxt = dbp_pkg::DS_IDLE;
                end else if (!dir_r && LINK.outbound_strobe) begin
                    rb_push = 1'b1;
                    hd_pop  = 1'b1;
                    st_nxt  = dbp_pkg::DS_IDLE;
                end
            end
            default: begin
                req_nxt = 1'b0;
                st_nxt  = dbp_pkg::DS_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            st_r  <= dbp_pkg::DS_IDLE;
            req_r <= 1'b0;
            dir_r <= 1'b0;
            adr_r <= dbp_pkg::ADDR_RST;
            dat_r <= dbp_pkg::DATA_RST;
        end else begin
            st_r  <= st_nxt;
            req_r <= req_nxt;
            dir_r <= dir_nxt;
            adr_r <= adr_nxt;
            dat_r <= dat_nxt;
        end
    end

    // lines held steady from request until the transfer ends
    assign LINK.break_request        = req_r;
    assign LINK.device_address_lines = adr_r;
    assign LINK.data_in_dir          = dir_r;
    assign LINK.inbound_data_lines   = dat_r;
endmodule

//--- hw/dbp_link_if.sv
// link between the processor break port and a cycle-stealing device
// assumes both ends share one clock; no clocking block
`timescale 1ns/1ps
interface dbp_link_if;
    logic                         break_request;
    logic [dbp_pkg::ADDR_W-1:0]   device_address_lines;
    logic                         data_in_dir;
    logic [dbp_pkg::DATA_W-1:0]   inbound_data_lines;
    logic                         address_accept_pulse;
    logic                         inbound_strobe;
    logic                         outbound_strobe;
    logic [dbp_pkg::DATA_W-1:0]   buffered_memory_out;

    modport proc (
        input  break_request,
        input  device_address_lines,
        input  data_in_dir,
        input  inbound_data_lines,
        output address_accept_pulse,
        output inbound_strobe,
        output outbound_strobe,
        output buffered_memory_out
    );
    modport dev (
        output break_request,
        output device_address_lines,
        output data_in_dir,
        output inbound_data_lines,
        input  address_accept_pulse,
        input  inbound_strobe,
        input  outbound_strobe,
        input  buffered_memory_out
    );
endinterface

//--- hw/dbp_pkg.sv
// shared constants for the data break port: widths, cycle phases, states
// assumes one clock at 10 MHz; one processor cycle is five clock phases
package dbp_pkg;
    localparam int ADDR_W     = 15;          // memory address width
    localparam int DATA_W     = 18;          // memory word width
    localparam int CMD_W      = 1 + ADDR_W + DATA_W;
    localparam int CMD_DIR_B  = CMD_W - 1;   // direction bit of a command
    localparam int CMD_ADDR_L = DATA_W;      // address field low bit
    localparam int BUF_DEPTH  = 2;           // entries in each data buffer
    localparam int CLK_MHZ    = 10;
    localparam int PHASE_NS   = 100;         // one timing phase
    localparam int PHASE_CLKS = (PHASE_NS * CLK_MHZ + 999) / 1000;

    // timing phases of one processor cycle
    typedef enum logic [2:0] {
        PH_T1 = 3'h0,
        PH_T2 = 3'h1,
        PH_T3 = 3'h2,
        PH_T4 = 3'h3,
        PH_T5 = 3'h4
    } dbp_phase_t;

    // device end sequencing
    typedef enum logic [1:0] {
        DS_IDLE = 2'h0,
        DS_REQ  = 2'h1,
        DS_XFER = 2'h2
    } dbp_dstate_t;

    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [DATA_W-1:0] DATA_RST = 18'h00000;
endpackage

//--- hw/dbp_proc.sv
// processor end of the data break port: sync, break state, timed pulses
// assumes the device keeps its lines steady from request until the strobe
`timescale 1ns/1ps
module dbp_proc (
    input  wire logic                       REF_CLK,
    input  wire logic                       RST_B,
    dbp_link_if.proc                        LINK,
    input  wire logic                       INSTR_DONE,
    input  wire logic [dbp_pkg::DATA_W-1:0] MEM_RDATA,
    output logic                            MEM_RE,
    output logic                            MEM_WE,
    output logic [dbp_pkg::ADDR_W-1:0]      MEM_ADDR,
    output logic [dbp_pkg::DATA_W-1:0]      MEM_WDATA,
    output logic                            BREAK_PENDING,
    output logic                            BREAK_STATE
);
    localparam int PCW = $clog2(dbp_pkg::PHASE_CLKS + 1);

    dbp_pkg::dbp_phase_t            phase_r, phase_nxt;
    logic [PCW-1:0]                 pcnt_r, pcnt_nxt;
    logic                           sync_r, sync_nxt;
    logic                           brk_r, brk_nxt;
    logic                           dir_r, dir_nxt;
    logic [dbp_pkg::ADDR_W-1:0]     maddr_r, maddr_nxt;
    logic [dbp_pkg::DATA_W-1:0]     mbuf_r, mbuf_nxt;
    logic                           acc_r, acc_nxt;
    logic                           istb_r, istb_nxt;
    logic                           ostb_r, ostb_nxt;
    logic                           re_r, re_nxt;
    logic                           we_r, we_nxt;
    logic                           qual_nxt;
    logic                           phase_end;
    logic                           edge_t1, edge_t3, edge_t5;

    // phase sequencer: each phase lasts PHASE_CLKS clocks
    always_comb begin
        phase_end = (pcnt_r == PCW'(dbp_pkg::PHASE_CLKS - 1));
        pcnt_nxt  = phase_end ? '0 : pcnt_r + PCW'(1);
        phase_nxt = phase_r;
        if (phase_end) begin
            if (phase_r == dbp_pkg::PH_T5) begin
                phase_nxt = dbp_pkg::PH_T1;
            end else begin
                phase_nxt = dbp_pkg::dbp_phase_t'(phase_r + 3'h1);
            end
        end
        // first clock of T1, T3 and T5, so a pulse is one clock wide
        edge_t1 = phase_end && (phase_nxt == dbp_pkg::PH_T1);
        edge_t3 = phase_end && (phase_nxt == dbp_pkg::PH_T3);
        edge_t5 = phase_end && (phase_nxt == dbp_pkg::PH_T5);
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            phase_r <= dbp_pkg::PH_T1;
            pcnt_r  <= '0;
        end else begin
            phase_r <= phase_nxt;
            pcnt_r  <= pcnt_nxt;
        end
    end

    // break synchronisation and major state; both move only at end of T5
    always_comb begin
        sync_nxt = sync_r;
        brk_nxt  = brk_r;
        if (phase_end && phase_r == dbp_pkg::PH_T5) begin
            sync_nxt = LINK.break_request;
            // back-to-back breaks need no instruction boundary
            brk_nxt  = sync_nxt && (brk_r || INSTR_DONE);
        end
        qual_nxt = brk_nxt && sync_nxt;
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            sync_r <= 1'b0;
            brk_r  <= 1'b0;
        end else begin
            sync_r <= sync_nxt;
            brk_r  <= brk_nxt;
        end
    end

    // transfer pulses, address and buffer registers
    always_comb begin
        maddr_nxt = maddr_r;
        mbuf_nxt  = mbuf_r;
        dir_nxt  = dir_r;
        acc_nxt  = qual_nxt && edge_t1;
        re_nxt   = 1'b0;
        istb_nxt = qual_nxt && edge_t3 && dir_r;
        ostb_nxt = qual_nxt && edge_t3 && !dir_r;
        we_nxt   = qual_nxt && edge_t5 && dir_r;
        if (acc_nxt) begin
            maddr_nxt = LINK.device_address_lines;
            dir_nxt = LINK.data_in_dir;
            re_nxt  = !LINK.data_in_dir;
        end
        // read data is taken at the end of the clock the read strobe is high
        if (re_r) begin
            mbuf_nxt = MEM_RDATA;
        end
        if (istb_nxt) begin
            mbuf_nxt = LINK.inbound_data_lines;
        end
    end

    always_ff @(posedge REF_CLK or negedge RST_B) begin
        if (!RST_B) begin
            maddr_r <= dbp_pkg::ADDR_RST;
            mbuf_r  <= dbp_pkg::DATA_RST;
            dir_r  <= 1'b0;
            acc_r  <= 1'b0;
            re_r   <= 1'b0;
            istb_r <= 1'b0;
            ostb_r <= 1'b0;
            we_r   <= 1'b0;
        end else begin
            maddr_r <= maddr_nxt;
            mbuf_r  <= mbuf_nxt;
            dir_r  <= dir_nxt;
            acc_r  <= acc_nxt;
            re_r   <= re_nxt;
            istb_r <= istb_nxt;
            ostb_r <= ostb_nxt;
            we_r   <= we_nxt;
        end
    end

    // outputs straight from flops
    assign LINK.address_accept_pulse = acc_r;
    assign LINK.inbound_strobe       = istb_r;
    assign LINK.outbound_strobe      = ostb_r;
    assign LINK.buffered_memory_out  = mbuf_r;
    assign MEM_RE                    = re_r;
    assign MEM_WE                    = we_r;
    assign MEM_ADDR                  = maddr_r;
    assign MEM_WDATA                 = mbuf_r;
    assign BREAK_PENDING             = sync_r;
    assign BREAK_STATE               = brk_r;
endmodule
